// File: pkg/lsp_regs.vh
`ifndef LSP_REGS_VH
`define LSP_REGS_VH
// assignment source selects
`define LSP_SRC_NONE      2'h0
`define LSP_SRC_CMD       2'h1
`define LSP_SRC_DI        2'h2
`define LSP_SRC_DI_LOW    2'h3
// stop types
`define LSP_STOP_RAMP     2'h0
`define LSP_STOP_QUICK    2'h1
`define LSP_STOP_FREE     2'h2
`define LSP_STOP_TYPE_RST 2'h2
// first command bit usable in any profile
`define LSP_CMD_FREE_LO   4'hb
// zone codes
`define LSP_ZONE_MID      2'h0
`define LSP_ZONE_SLOW     2'h1
`define LSP_ZONE_STOP     2'h2
`endif

// File: design/lsp_limit_pos.v
`include "lsp_regs.vh"

module lsp_limit_pos
#(
   parameter REF_W  = 16,
   parameter DIST_W = 24,
   parameter N_DI   = 8
)
(
   input  wire              clk_i,
   input  wire              rst_b_i,
   input  wire [N_DI-1:0]   di_i,
   input  wire [15:0]       cmd_word_i,
   input  wire              cmd_word_ext_i,
   input  wire [1:0]        stop_fw_src_i,
   input  wire [3:0]        stop_fw_sel_i,
   input  wire [1:0]        stop_rv_src_i,
   input  wire [3:0]        stop_rv_sel_i,
   input  wire [1:0]        slow_fw_src_i,
   input  wire [3:0]        slow_fw_sel_i,
   input  wire [1:0]        slow_rv_src_i,
   input  wire [3:0]        slow_rv_sel_i,
   input  wire [1:0]        dis_src_i,
   input  wire [3:0]        dis_sel_i,
   input  wire              edge_rise_i,
   input  wire [1:0]        stop_type_i,
   input  wire              stop_type_we_i,
   input  wire              long_cam_i,
   input  wire              cfg_reset_i,
   input  wire              run_fw_i,
   input  wire              run_rv_i,
   input  wire              standstill_i,
   input  wire [REF_W-1:0]  ref_i,
   input  wire [REF_W-1:0]  low_speed_i,
   input  wire              dist_en_i,
   input  wire [DIST_W-1:0] dist_i,
   input  wire [REF_W-1:0]  speed_est_i,
   input  wire              nv_valid_i,
   input  wire [3:0]        nv_zone_i,
   input  wire              power_down_i,
   output reg  [REF_W-1:0]  ref_o,
   output reg               stop_req_o,
   output reg  [1:0]        stop_kind_o,
   output reg               run_fw_ok_o,
   output reg               run_rv_ok_o,
   output reg               pos_valid_o,
   output reg               nv_we_o,
   output reg  [3:0]        nv_zone_o
);
//////////////////////////////////////////////////////////////////////////////
// source selection
function pick;
   input [1:0]      src;
   input [3:0]      sel;
   input [N_DI-1:0] di;
   input [15:0]     cw;
   input            ext;
   begin
      case (src)
         `LSP_SRC_CMD    : pick = (ext || sel >= `LSP_CMD_FREE_LO) ? cw[sel] : 1'b1;
         `LSP_SRC_DI     : pick = di[sel[2:0]];
         `LSP_SRC_DI_LOW : pick = ~di[sel[2:0]];
         default         : pick = 1'b1;
      endcase
   end
endfunction

//////////////////////////////////////////////////////////////////////////////
// shared zone and distance helpers
function zone_step;
   input held;
   input set_ev;
   input clr_ev;
   begin
      zone_step = (held | set_ev) & ~clr_ev;
   end
endfunction

function [DIST_W-1:0] widen;
   input [REF_W-1:0] v;
   begin
      widen = {{(DIST_W-REF_W){1'b0}}, v};
   end
endfunction

// three-stage synchroniser for pins
reg [N_DI-1:0] di_s1;
reg [N_DI-1:0] di_s2;
reg [N_DI-1:0] di_s3;
reg [N_DI-1:0] di_f;
always @(posedge clk_i or negedge rst_b_i)
begin
   if (!rst_b_i)
   begin
      di_s1 <= {N_DI{1'b1}};
      di_s2 <= {N_DI{1'b1}};
      di_s3 <= {N_DI{1'b1}};
      di_f  <= {N_DI{1'b1}};
   end
   else
   begin
      di_s1 <= di_i;
      di_s2 <= di_s1;
      di_s3 <= di_s2;
      di_f  <= (~(di_s2 ^ di_s3) & di_s3) | ((di_s2 ^ di_s3) & di_f);
   end
end

wire fw_stop_a = (stop_fw_src_i != `LSP_SRC_NONE);
wire rv_stop_a = (stop_rv_src_i != `LSP_SRC_NONE);
wire fw_stop_l = pick(stop_fw_src_i, stop_fw_sel_i, di_f, cmd_word_i, cmd_word_ext_i);
wire rv_stop_l = pick(stop_rv_src_i, stop_rv_sel_i, di_f, cmd_word_i, cmd_word_ext_i);
wire fw_slow_l = pick(slow_fw_src_i, slow_fw_sel_i, di_f, cmd_word_i, cmd_word_ext_i);
wire rv_slow_l = pick(slow_rv_src_i, slow_rv_sel_i, di_f, cmd_word_i, cmd_word_ext_i);
wire dis_a     = (dis_src_i != `LSP_SRC_NONE);
wire disable_l = dis_a & pick(dis_src_i, dis_sel_i, di_f, cmd_word_i, cmd_word_ext_i);

//////////////////////////////////////////////////////////////////////////////
// edge detection
reg [3:0] prev;
wire [3:0] cur = {rv_stop_l, fw_stop_l, rv_slow_l, fw_slow_l};
wire [3:0] act_e = edge_rise_i ? (cur & ~prev) : (~cur & prev);
wire [3:0] clr_e = edge_rise_i ? (~cur & prev) : (cur & ~prev);
always @(posedge clk_i or negedge rst_b_i)
begin
   if (!rst_b_i)
      prev <= 4'hf;
   else
      prev <= cur;
end

//////////////////////////////////////////////////////////////////////////////
// stop type holding
reg [1:0] stop_type;
always @(posedge clk_i or negedge rst_b_i)
begin
   if (!rst_b_i)
      stop_type <= `LSP_STOP_TYPE_RST;
   else if (stop_type_we_i && (fw_stop_a || rv_stop_a) && stop_type_i != 2'h3)
      stop_type <= stop_type_i;
end

//////////////////////////////////////////////////////////////////////////////
// zone state, one flag per sensor: slow fw, slow rv, stop fw, stop rv
reg  [3:0]        zone;
reg               valid;
reg               restored;
reg               dist_run;
reg  [DIST_W-1:0] dist_acc;
reg               dist_hit;
wire              moving_fw = run_fw_i & ~run_rv_i;
wire              moving_rv = run_rv_i & ~run_fw_i;
wire [3:0]        next_zone;
wire              any_zone  = |zone;
// same set/clear logic for all four sensors, direction matched; stop flags set only when their stop source is assigned
wire              quiet_lvl = edge_rise_i ? ~|cur : &cur;
assign next_zone[0] = zone_step(zone[0], act_e[0] & moving_fw, clr_e[0] & moving_rv);
assign next_zone[1] = zone_step(zone[1], act_e[1] & moving_rv, clr_e[1] & moving_fw);
assign next_zone[2] = zone_step(zone[2], act_e[2] & moving_fw & fw_stop_a, clr_e[2] & moving_rv);
assign next_zone[3] = zone_step(zone[3], act_e[3] & moving_rv & rv_stop_a, clr_e[3] & moving_fw);

always @(posedge clk_i or negedge rst_b_i)
begin
   if (!rst_b_i)
   begin
      zone     <= 4'h0;
      valid    <= 1'b0;
      restored <= 1'b0;
   end
   else if (cfg_reset_i)
   begin
      zone  <= 4'h0;
      valid <= 1'b0;
   end
   else if (!restored)
   begin
      restored <= 1'b1;
      zone     <= nv_valid_i ? nv_zone_i : 4'h0;
      valid    <= nv_valid_i;
   end
   else
   begin
      zone <= next_zone;
      if (long_cam_i)
         valid <= 1'b1;
      else if (!any_zone && (moving_fw || moving_rv) && quiet_lvl)
         valid <= 1'b1;
   end
end

//////////////////////////////////////////////////////////////////////////////
// distance stop after forward or reverse slowdown
wire slow_edge = (act_e[0] & moving_fw) | (act_e[1] & moving_rv);
always @(posedge clk_i or negedge rst_b_i)
begin
   if (!rst_b_i)
   begin
      dist_run <= 1'b0;
      dist_acc <= {DIST_W{1'b0}};
      dist_hit <= 1'b0;
   end
   else if (!dist_en_i || standstill_i)
   begin
      dist_run <= 1'b0;
      dist_acc <= {DIST_W{1'b0}};
      dist_hit <= 1'b0;
   end
   else if (slow_edge)
   begin
      dist_run <= 1'b1;
      dist_acc <= widen(speed_est_i);
   end
   else if (dist_run && dist_acc >= dist_i)
   begin
      dist_run <= 1'b0;
      dist_hit <= 1'b1;
   end
   else if (dist_run)
      dist_acc <= dist_acc + widen(speed_est_i);
end

//////////////////////////////////////////////////////////////////////////////
// outputs
wire fw_blk = zone[2] | (fw_stop_a & ~fw_stop_l);
wire rv_blk = zone[3] | (rv_stop_a & ~rv_stop_l);
wire both_b = fw_stop_a & rv_stop_a & ~fw_stop_l & ~rv_stop_l;
wire lim_stop = ((fw_blk & moving_fw) | (rv_blk & moving_rv)) & ~disable_l;
wire clamp = ((zone[0] & moving_fw) | (zone[1] & moving_rv)) & ~disable_l;

//////////////////////////////////////////////////////////////////////////////
// next output values
reg  [REF_W-1:0] next_ref;
reg              next_stop_req;
reg  [1:0]       next_stop_kind;
reg              next_fw_ok;
reg              next_rv_ok;
always @*
begin
   next_ref       = ref_i;
   next_stop_req  = lim_stop | (dist_hit & ~disable_l);
   next_stop_kind = stop_type;
   next_fw_ok     = disable_l | (~fw_blk & ~both_b & (standstill_i | ~run_rv_i));
   next_rv_ok     = disable_l | (~rv_blk & ~both_b & (standstill_i | ~run_fw_i));
   if (clamp && ref_i > low_speed_i)
      next_ref = low_speed_i;
   if (dist_hit && !lim_stop)
      next_stop_kind = `LSP_STOP_RAMP;
end

always @(posedge clk_i or negedge rst_b_i)
begin
   if (!rst_b_i)
   begin
      ref_o       <= {REF_W{1'b0}};
      stop_req_o  <= 1'b0;
      stop_kind_o <= `LSP_STOP_TYPE_RST;
      run_fw_ok_o <= 1'b0;
      run_rv_ok_o <= 1'b0;
      pos_valid_o <= 1'b0;
      nv_we_o     <= 1'b0;
      nv_zone_o   <= 4'h0;
   end
   else
   begin
      ref_o       <= next_ref;
      stop_req_o  <= next_stop_req;
      stop_kind_o <= next_stop_kind;
      run_fw_ok_o <= next_fw_ok;
      run_rv_ok_o <= next_rv_ok;
      pos_valid_o <= valid;
      nv_we_o     <= power_down_i;
      nv_zone_o   <= zone;
   end
end

endmodule // lsp_limit_pos

// File: verif/lsp_switch_model.sv
module lsp_switch_model
#(
   parameter int SLOW_AT = 6
)
(
   input  wire logic       clk_i,
   input  wire logic       run_fw_i,
   input  wire logic       run_rv_i,
   output logic [7:0]      di_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int pos = 0;
   // carriage moves one step a cycle while a run command is held
   always @(posedge clk_i)
   begin
      pos <= pos + int'(run_fw_i) - int'(run_rv_i);
   end
   // forward slowdown cam: contact opens beyond the cam point
   assign di_o = {7'h7f, pos < SLOW_AT};
endmodule // lsp_switch_model

// File: verif/lsp_limit_pos_checker.sv
module lsp_limit_pos_checker
#(
   parameter REF_W = 16
)
(
   input logic             clk_i,
   input logic             rst_b_i,
   input logic [15:0]      cmd_word_i,
   input logic [1:0]       dis_src_i,
   input logic [3:0]       dis_sel_i,
   input logic             run_fw_i,
   input logic             standstill_i,
   input logic [REF_W-1:0] ref_i,
   input logic [REF_W-1:0] low_speed_i,
   input logic             power_down_i,
   input logic [REF_W-1:0] ref_o,
   input logic             stop_req_o,
   input logic [1:0]       stop_kind_o,
   input logic             run_fw_ok_o,
   input logic             run_rv_ok_o,
   input logic             nv_we_o,
   input logic [3:0]       nv_zone_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   wire lim_on = dis_src_i == 2'h0;
   sequence s_dis_on;
      dis_src_i == 2'h1 && dis_sel_i == 4'hc && cmd_word_i[12];
   endsequence
   sequence s_fw_stop;
      nv_zone_o[2] && lim_on;
   endsequence
   property p_kind;
      stop_kind_o != 2'h3;
   endproperty
   a_kind: assert property (p_kind) else $error("bad stop kind");
   property p_fw_stop;
      s_fw_stop ##0 run_fw_i && !standstill_i |-> ##[1:2] stop_req_o;
   endproperty
   a_fw_stop: assert property (p_fw_stop) else $error("no stop");
   property p_no_fw;
      s_fw_stop |-> ##[1:2] !run_fw_ok_o;
   endproperty
   a_no_fw: assert property (p_no_fw) else $error("fw allowed");
   property p_both;
      nv_zone_o[3:2] == 2'h3 && lim_on |-> ##[1:2] !run_fw_ok_o && !run_rv_ok_o;
   endproperty
   a_both: assert property (p_both) else $error("restart allowed");
   property p_still;
      $rose(run_rv_ok_o) && nv_zone_o[2] |-> $past(standstill_i) || $past(standstill_i, 2);
   endproperty
   a_still: assert property (p_still) else $error("rv before stop");
   property p_clamp;
      nv_zone_o[0] && run_fw_i && lim_on && ref_i > low_speed_i |-> ##[1:2] ref_o <= low_speed_i;
   endproperty
   a_clamp: assert property (p_clamp) else $error("no clamp");
   property p_dis;
      s_dis_on [*3] |-> !stop_req_o;
   endproperty
   a_dis: assert property (p_dis) else $error("stop while off");
   property p_nvwe;
      $rose(power_down_i) |=> nv_we_o;
   endproperty
   a_nvwe: assert property (p_nvwe) else $error("no save");
endmodule // lsp_limit_pos_checker
bind lsp_limit_pos lsp_limit_pos_checker #(.REF_W(REF_W)) u_chk (.clk_i, .rst_b_i, .cmd_word_i,
   .dis_src_i, .dis_sel_i, .run_fw_i, .standstill_i, .ref_i, .low_speed_i, .power_down_i, .ref_o,
   .stop_req_o, .stop_kind_o, .run_fw_ok_o, .run_rv_ok_o, .nv_we_o, .nv_zone_o);

// File: verif/test_lsp_limit_pos.sv
module test_lsp_limit_pos;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, rst_b_i = 0, cmd_word_ext_i = 0, edge_rise_i = 0, stop_type_we_i = 0;
   logic long_cam_i = 0, cfg_reset_i = 0, run_fw_i = 0, run_rv_i = 0, standstill_i = 0;
   logic dist_en_i = 0, nv_valid_i = 0, power_down_i = 0;
   logic [1:0] stop_fw_src_i = 0, stop_rv_src_i = 0, slow_fw_src_i = 0, slow_rv_src_i = 0;
   logic [1:0] dis_src_i = 0, stop_type_i = 0;
   logic [3:0] stop_fw_sel_i = 0, stop_rv_sel_i = 0, slow_fw_sel_i = 0, slow_rv_sel_i = 0;
   logic [3:0] dis_sel_i = 0, nv_zone_i = 0;
   logic [15:0] cmd_word_i = 16'hffff, ref_i = 16'h03e8, low_speed_i = 16'h0064, speed_est_i = 0;
   logic [23:0] dist_i = 0;
   wire [7:0] di_i;
   wire [15:0] ref_o;
   wire [1:0] stop_kind_o;
   wire [3:0] nv_zone_o;
   wire stop_req_o, run_fw_ok_o, run_rv_ok_o, pos_valid_o, nv_we_o;
   int error_cnt = 0, checks = 0;
   lsp_limit_pos i_lsp_limit_pos (.clk_i, .rst_b_i, .di_i, .cmd_word_i, .cmd_word_ext_i,
      .stop_fw_src_i, .stop_fw_sel_i, .stop_rv_src_i, .stop_rv_sel_i, .slow_fw_src_i,
      .slow_fw_sel_i, .slow_rv_src_i, .slow_rv_sel_i, .dis_src_i, .dis_sel_i, .edge_rise_i,
      .stop_type_i, .stop_type_we_i, .long_cam_i, .cfg_reset_i, .run_fw_i, .run_rv_i,
      .standstill_i, .ref_i, .low_speed_i, .dist_en_i, .dist_i, .speed_est_i, .nv_valid_i,
      .nv_zone_i, .power_down_i, .ref_o, .stop_req_o, .stop_kind_o, .run_fw_ok_o,
      .run_rv_ok_o, .pos_valid_o, .nv_we_o, .nv_zone_o);
   lsp_switch_model i_lsp_switch_model (.clk_i, .run_fw_i, .run_rv_i, .di_o(di_i));
   always #12.5 clk_i = ~clk_i;
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #2;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr_type(input logic [1:0] k);
      stop_type_i = k;
      stop_type_we_i = 1;
      cyc(1);
      stop_type_we_i = 0;
   endtask
   task end_of_test;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      #50000;
      error_cnt++;
      end_of_test;
   end
   initial
   begin
      cyc(8);
      rst_b_i = 1;
      cyc(2);
      chk(stop_kind_o, 16'h0002);
      chk(pos_valid_o, 0);
      slow_fw_src_i = 2'h2;
      run_fw_i = 1;
      cyc(16);
      chk(ref_o, 16'h0064);
      chk(pos_valid_o, 1);
      dis_src_i = 2'h1;
      dis_sel_i = 4'hc;
      cyc(4);
      chk(ref_o, 16'h03e8);
      dis_src_i = 2'h0;
      run_fw_i = 0;
      run_rv_i = 1;
      cyc(3);
      chk(ref_o, 16'h03e8);
      chk(nv_zone_o[0], 1);
      cyc(20);
      chk(nv_zone_o[0], 0);
      run_rv_i = 0;
      run_fw_i = 1;
      cyc(20);
      power_down_i = 1;
      cyc(2);
      chk(nv_we_o, 1);
      chk(nv_zone_o, 16'h0001);
      power_down_i = 0;
      run_fw_i = 0;
      slow_fw_src_i = 2'h0;
      $display("slowdown test done");
      wr_type(2'h1);
      stop_fw_src_i = 2'h1;
      stop_fw_sel_i = 4'hb;
      for (int k = 2; k >= 0; k--)
      begin
         if (k < 2)
            wr_type(k[1:0]);
         run_rv_i = 1;
         cmd_word_i[11] = 1;
         cyc(4);
         chk(stop_req_o, 0);
         run_rv_i = 0;
         run_fw_i = 1;
         cmd_word_i[11] = 0;
         cyc(4);
         chk(stop_req_o, 1);
         chk(stop_kind_o, k[15:0]);
         chk({run_fw_ok_o, run_rv_ok_o}, 0);
         standstill_i = 1;
         cyc(3);
         chk(run_rv_ok_o, 1);
         standstill_i = 0;
         run_fw_i = 0;
      end
      $display("stop test done");
      stop_rv_src_i = 2'h1;
      stop_rv_sel_i = 4'hd;
      run_rv_i = 1;
      cmd_word_i[13] = 0;
      standstill_i = 1;
      cyc(5);
      chk({run_fw_ok_o, run_rv_ok_o}, 0);
      dis_src_i = 2'h1;
      cyc(4);
      chk(stop_req_o, 0);
      chk(run_fw_ok_o, 1);
      $display("restart test done");
      end_of_test;
   end
endmodule // test_lsp_limit_pos
